// ### design/gpio_port_defines.svh
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define GPIO_IDX_W 3
`define GPIO_IDX_PORT_A 3'h0
`define GPIO_IDX_PORT_B 3'h1
`define GPIO_IDX_PORT_C 3'h2
`define GPIO_IDX_PORT_D 3'h3
`define GPIO_IDX_DIR 3'h4
`define GPIO_IDX_IRQ_CTRL 3'h5
`define GPIO_IDX_EVT_STATUS 3'h6
`define GPIO_IDX_EVT_MASK 3'h7
`define GPIO_ADDR_LSB 2
`define GPIO_ADDR_ALIGN_ZERO 2'h0

// ****************************************************************
// field positions
// ****************************************************************
`define GPIO_PORTS 4
`define GPIO_PORT_W 8
`define GPIO_IRQ_EN_BIT 7
`define GPIO_IRQ_PEND_BIT 6
`define GPIO_MODE_MSB 1
`define GPIO_MODE_LSB 0
`define GPIO_EVT_LINE0_BIT 0
`define GPIO_IRQ_LINE 0

// ****************************************************************
// reset values
// ****************************************************************
`define GPIO_LATCH_RESET 8'h00
`define GPIO_DIR_RESET 4'h0
`define GPIO_MODE_RESET 2'h0
`define GPIO_EVT_RESET 8'h00
`define GPIO_BUS_RESET 32'h0000_0000
`define GPIO_SYNC_RESET 1'b1

`endif

// ### design/gpio_port_pkg.sv
package gpio_port_pkg;

    // trigger codes 00..11 in declaration order
    typedef enum logic [1:0] {
        trig_low_level,
        trig_high_level,
        trig_falling_edge,
        trig_rising_edge
    } trigger_mode_e;

endpackage : gpio_port_pkg

// ### design/irq_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defines.svh"

module irq_detect (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic line,
    input wire logic enable,
    input wire logic [1:0] mode,
    input wire logic clear,
    output logic hit,
    output logic pending
);

    logic prev_q;
    logic pending_q;
    gpio_port_pkg::trigger_mode_e trig;

    assign trig = gpio_port_pkg::trigger_mode_e'(mode);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_q <= `GPIO_SYNC_RESET;
        end else begin
            prev_q <= line;
        end
    end

    // level modes fire every cycle the level holds
    always_comb begin
        hit = 1'b0;
        unique case (trig)
            gpio_port_pkg::trig_low_level: hit = !line;
            gpio_port_pkg::trig_high_level: hit = line;
            gpio_port_pkg::trig_falling_edge: hit = prev_q & !line;
            gpio_port_pkg::trig_rising_edge: hit = !prev_q & line;
        endcase
        hit = hit & enable;
    end

    // a new hit wins over a clearing read in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
        end else if (hit) begin
            pending_q <= 1'b1;
        end else if (clear) begin
            pending_q <= 1'b0;
        end
    end

    assign pending = pending_q;

endmodule : irq_detect
`default_nettype wire

// ### design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defines.svh"

module pin_sync #(
    parameter int W = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin_raw,
    output logic [W-1:0] pin_clean
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] clean_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_q <= {W{`GPIO_SYNC_RESET}};
            s2_q <= {W{`GPIO_SYNC_RESET}};
            s3_q <= {W{`GPIO_SYNC_RESET}};
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clean_q <= {W{`GPIO_SYNC_RESET}};
        end else begin
            clean_q <= (s2_q & s3_q) | (clean_q & (s2_q | s3_q));
        end
    end

    assign pin_clean = clean_q;

endmodule : pin_sync
`default_nettype wire

// ### design/quad_byte_digital_io_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defines.svh"

module quad_byte_digital_io_port #(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    output logic irq
);

    localparam int NP = `GPIO_PORTS;
    localparam int PW = `GPIO_PORT_W;
    localparam int NL = NP * PW;

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [NL-1:0] pin_clean;
    logic [NL-1:0] out_q;
    logic [NL-1:0] oe_q;
    logic [NP-1:0] dir_q;
    logic irq_gate_on_q;
    logic [1:0] trig_mode_q;
    logic [PW-1:0] evt_status_q;
    logic [PW-1:0] evt_mask_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic access;
    logic taken;
    logic wr_done;
    logic rd_done;
    logic mapped;
    logic [`GPIO_IDX_W-1:0] idx;
    logic [PW-1:0] rd_byte;
    logic [PW-1:0] port_rd [NP];
    logic [PW-1:0] evt_set;
    logic irq_hit;
    logic irq_pending_flag;
    logic irq_clear;
    logic trigger_mode_hi;
    logic trigger_mode_lo;
    logic port_a_line0;
    logic first_acc;
    logic dir_wr;
    logic ctrl_wr;
    logic status_wr;
    logic mask_wr;
    logic [PW-1:0] wr_byte;

    // ****************************************************************
    // address decode
    // ****************************************************************
    // an address is mapped when word aligned and inside the eight words
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] hi;
        hi = a >> (`GPIO_ADDR_LSB + `GPIO_IDX_W);
        addr_ok = (a[`GPIO_ADDR_LSB-1:0] == `GPIO_ADDR_ALIGN_ZERO)
            && (hi == '0);
    endfunction : addr_ok

    function automatic logic [`GPIO_IDX_W-1:0] addr_idx(
        input logic [ADDR_W-1:0] a
    );
        addr_idx = a[`GPIO_ADDR_LSB +: `GPIO_IDX_W];
    endfunction : addr_idx

    assign mapped = addr_ok(paddr);
    assign idx = addr_idx(paddr);

    // ****************************************************************
    // apb handshake
    // ****************************************************************
    // every access takes one wait state: data is prepared in the first
    // access cycle and pready is high in the second
    assign access = psel & penable;
    assign first_acc = access & !pready_q;
    assign taken = access & pready_q;
    assign wr_done = taken & pwrite & mapped;
    assign rd_done = taken & !pwrite & mapped;
    assign wr_byte = pwdata[PW-1:0];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= first_acc;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= first_acc & !mapped;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_q <= `GPIO_BUS_RESET;
        end else if (first_acc) begin
            if (mapped & !pwrite) begin
                prdata_q <= {{(32-PW){1'b0}}, rd_byte};
            end else begin
                prdata_q <= `GPIO_BUS_RESET;
            end
        end
    end

    // ****************************************************************
    // register strobes
    // ****************************************************************
    // a register acts only at the edge that completes its access
    function automatic logic reg_hit(
        input logic done,
        input logic [`GPIO_IDX_W-1:0] at,
        input logic [`GPIO_IDX_W-1:0] want
    );
        reg_hit = done && (at == want);
    endfunction : reg_hit

    assign dir_wr = reg_hit(wr_done, idx, `GPIO_IDX_DIR);
    assign ctrl_wr = reg_hit(wr_done, idx, `GPIO_IDX_IRQ_CTRL);
    assign status_wr = reg_hit(wr_done, idx, `GPIO_IDX_EVT_STATUS);
    assign mask_wr = reg_hit(wr_done, idx, `GPIO_IDX_EVT_MASK);

    // ****************************************************************
    // pin input synchroniser
    // ****************************************************************
    pin_sync #(
        .W(NL)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_raw(pin_in),
        .pin_clean(pin_clean)
    );

    // ****************************************************************
    // output latches
    // ****************************************************************
    // latches take writes whatever the port direction
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int p = 0; p < NP; p++) begin
                out_q[p*PW +: PW] <= `GPIO_LATCH_RESET;
            end
        end else if (wr_done) begin
            for (int p = 0; p < NP; p++) begin
                if (idx == `GPIO_IDX_W'(p)) begin
                    out_q[p*PW +: PW] <= wr_byte;
                end
            end
        end
    end

    // ****************************************************************
    // direction and output enables
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dir_q <= `GPIO_DIR_RESET;
        end else if (dir_wr) begin
            dir_q <= pwdata[NP-1:0];
        end
    end

    // one direction bit drives all eight enables of its port
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            oe_q <= '0;
        end else if (dir_wr) begin
            for (int p = 0; p < NP; p++) begin
                oe_q[p*PW +: PW] <= {PW{pwdata[p]}};
            end
        end
    end

    // ****************************************************************
    // port readback
    // ****************************************************************
    // an output port reads its latch, an input port its synced pins
    function automatic logic [PW-1:0] port_view(
        input logic drive,
        input logic [PW-1:0] latch,
        input logic [PW-1:0] pins
    );
        port_view = drive ? latch : pins;
    endfunction : port_view

    // control register image: enable, pending, mode, the rest zero
    function automatic logic [PW-1:0] ctrl_byte(
        input logic en,
        input logic pend,
        input logic [1:0] mode
    );
        ctrl_byte = '0;
        ctrl_byte[`GPIO_IRQ_EN_BIT] = en;
        ctrl_byte[`GPIO_IRQ_PEND_BIT] = pend;
        ctrl_byte[`GPIO_MODE_MSB:`GPIO_MODE_LSB] = mode;
    endfunction : ctrl_byte

    // an open input line reads one through the board pull-up
    for (genvar g = 0; g < NP; g++) begin : g_port_rd
        assign port_rd[g] = port_view(dir_q[g],
            out_q[g*PW +: PW],
            pin_clean[g*PW +: PW]);
    end

    always_comb begin
        rd_byte = '0;
        unique case (idx)
            `GPIO_IDX_PORT_A: rd_byte = port_rd[0];
            `GPIO_IDX_PORT_B: rd_byte = port_rd[1];
            `GPIO_IDX_PORT_C: rd_byte = port_rd[2];
            `GPIO_IDX_PORT_D: rd_byte = port_rd[3];
            `GPIO_IDX_DIR: begin
                rd_byte = '0;
                rd_byte[NP-1:0] = dir_q;
            end
            `GPIO_IDX_IRQ_CTRL: rd_byte = ctrl_byte(irq_gate_on_q,
                irq_pending_flag, {trigger_mode_hi, trigger_mode_lo});
            `GPIO_IDX_EVT_STATUS: rd_byte = evt_status_q;
            `GPIO_IDX_EVT_MASK: rd_byte = evt_mask_q;
        endcase
    end

    // ****************************************************************
    // interrupt control register
    // ****************************************************************
    assign trigger_mode_hi = trig_mode_q[`GPIO_MODE_MSB];
    assign trigger_mode_lo = trig_mode_q[`GPIO_MODE_LSB];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_gate_on_q <= 1'b0;
            trig_mode_q <= `GPIO_MODE_RESET;
        end else if (ctrl_wr) begin
            irq_gate_on_q <= pwdata[`GPIO_IRQ_EN_BIT];
            trig_mode_q <= pwdata[`GPIO_MODE_MSB:`GPIO_MODE_LSB];
        end
    end

    // ****************************************************************
    // trigger detection
    // ****************************************************************
    // the monitored line is the synchronised pin, also when driven
    assign port_a_line0 = pin_clean[`GPIO_IRQ_LINE];
    assign irq_clear = reg_hit(rd_done, idx, `GPIO_IDX_IRQ_CTRL);

    irq_detect u_irq_detect (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .line(port_a_line0),
        .enable(irq_gate_on_q),
        .mode(trig_mode_q),
        .clear(irq_clear),
        .hit(irq_hit),
        .pending(irq_pending_flag)
    );

    // ****************************************************************
    // event status, mask and interrupt output
    // ****************************************************************
    always_comb begin
        evt_set = '0;
        evt_set[`GPIO_EVT_LINE0_BIT] = irq_hit;
    end

    // write one clears; a set in the same cycle wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            evt_status_q <= `GPIO_EVT_RESET;
        end else if (status_wr) begin
            evt_status_q <= (evt_status_q & ~wr_byte) | evt_set;
        end else begin
            evt_status_q <= evt_status_q | evt_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            evt_mask_q <= `GPIO_EVT_RESET;
        end else if (mask_wr) begin
            evt_mask_q <= wr_byte;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_status_q & evt_mask_q);
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign pin_out = out_q;
    assign pin_oe = oe_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

endmodule : quad_byte_digital_io_port
`default_nettype wire

// ### sim/field_rack.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// field side: drivers on the lines plus the pull-ups
// ****************************************************************
module field_rack (
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] ext_drive,
    input wire logic [31:0] ext_level,
    output logic [31:0] pin_in
);
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_drive[i]) begin
                pin_in[i] = ext_level[i];
            end else begin
                pin_in[i] = 1'b1;
            end
        end
    end
endmodule : field_rack

`default_nettype wire

// ### sim/quad_byte_digital_io_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defines.svh"

module quad_byte_digital_io_port_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] pin_in,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic done;
    logic rdd;
    logic map;
    logic [2:0] idx;
    assign done = psel && penable && pready;
    assign rdd = done && !pwrite;
    assign idx = paddr[4:2];
    assign map = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    access_len_a: assert property (s_setup ##1 s_wait |=> s_done ##1 !pready)
        else $error("access phase length wrong");
    slave_err_a: assert property (done |-> pslverr == !map)
        else $error("pslverr wrong");
    read_width_a: assert property (rdd |-> prdata[31:8] == 24'h0
        && (map || prdata == 32'h0)) else $error("read data bits wrong");
    dir_read_a: assert property (rdd && map && idx == `GPIO_IDX_DIR
        |-> prdata[7:0] == {4'h0, pin_oe[24], pin_oe[16], pin_oe[8],
        pin_oe[0]}) else $error("direction readback wrong");
    port_read_a: assert property (rdd && map && !idx[2]
        && pin_oe[{idx[1:0], 3'h0}]
        |-> prdata[7:0] == pin_out[{idx[1:0], 3'h0} +: 8])
        else $error("output port readback wrong");
    ctrl_read_a: assert property (rdd && map
        && idx == `GPIO_IDX_IRQ_CTRL |-> prdata[5:2] == 4'h0)
        else $error("control reserved bits set");
    oe_group_a: assert property (pin_oe == {{8{pin_oe[24]}},
        {8{pin_oe[16]}}, {8{pin_oe[8]}}, {8{pin_oe[0]}}})
        else $error("output enable not per port");
    oe_cause_a: assert property ($changed(pin_oe) |-> $past(done
        && pwrite && map && idx == `GPIO_IDX_DIR))
        else $error("output enable moved without write");
    out_hold_a: assert property ($changed(pin_out) |-> $past(done
        && pwrite && map && !idx[2])) else $error("latch moved");
    reset_state_a: assert property ($rose(rst_n) |-> pin_oe == 32'h0
        && !irq && pin_out == 32'h0) else $error("reset state wrong");
endmodule : quad_byte_digital_io_port_chk

bind quad_byte_digital_io_port quad_byte_digital_io_port_chk #(
    .ADDR_W(ADDR_W)
) chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

`default_nettype wire

// ### sim/quad_byte_digital_io_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defines.svh"

module quad_byte_digital_io_port_tb_top;
    logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, ext_drive;
    logic [31:0] ext_level, rnd, latch, rd, exp_w;
    logic [3:0] dir;
    logic [1:0] md;
    logic [7:0] bad_a [3] = '{8'h21, 8'h40, 8'hFC};
    int n_mismatch, check_count;

    quad_byte_digital_io_port #(.ADDR_W(8)) dut_u (.sys_clk(sys_clk),
        .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .irq(irq));
    field_rack rack_u (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_drive(ext_drive), .ext_level(ext_level), .pin_in(pin_in));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] oe_of(input logic [3:0] d);
        return {{8{d[3]}}, {8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
    endfunction : oe_of
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    task automatic chk_word(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk_word
    task automatic chk_flag(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s exp %b got %b", nm, e, g);
            n_mismatch++;
        end
    endtask : chk_flag
    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [2:0] i, input logic [31:0] d);
        apb({3'h0, i, 2'h0}, 1'b1, d);
    endtask : wr
    task automatic rdreg(input logic [2:0] i);
        apb({3'h0, i, 2'h0}, 1'b0, 32'h0);
    endtask : rdreg
    task automatic check_ports;
        exp_w = (oe_of(dir) & latch)
            | (~oe_of(dir) & ~(ext_drive & ~ext_level));
        for (int p = 0; p < 4; p++) begin
            rdreg(3'(p));
            chk_word("port", 32'(exp_w[8 * p +: 8]), rd);
        end
    endtask : check_ports

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        stop_test();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_drive, ext_level, latch, dir, n_mismatch, check_count} = '0;
        rnd = 32'h0001_7FD6;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk_flag("irq reset", 1'b0, irq);
        for (int p = 0; p < 6; p++) begin
            rdreg(3'(p));
            chk_word("reset read", (p < 4) ? 32'hFF : 32'h0, rd);
        end
        for (int k = 0; k < 8; k++) begin
            wr(`GPIO_IDX_DIR, 32'h0);
            dir = 4'h0;
            rnd = lfsr(rnd);
            latch = rnd;
            for (int p = 0; p < 4; p++) wr(3'(p), latch >> (8 * p));
            rnd = lfsr(rnd);
            ext_level <= rnd;
            rnd = lfsr(rnd);
            ext_drive <= rnd;
            repeat (6) @(posedge sys_clk);
            chk_word("oe in", 32'h0, pin_oe);
            check_ports();
            rnd = lfsr(rnd);
            if (k == 0) rnd[7:0] = 8'hFF;
            dir = rnd[3:0];
            wr(`GPIO_IDX_DIR, rnd);
            repeat (6) @(posedge sys_clk);
            chk_word("pin_oe", oe_of(dir), pin_oe);
            chk_word("pin_out", latch, pin_out);
            rdreg(`GPIO_IDX_DIR);
            chk_word("dir", {28'h0, dir}, rd);
            check_ports();
        end
        for (int b = 0; b < 3; b++) begin
            apb(bad_a[b], 1'b1, 32'hFFFF_FFFF);
            chk_flag("wr err", 1'b1, err);
            apb(bad_a[b], 1'b0, 32'h0);
            chk_flag("rd err", 1'b1, err);
            chk_word("rd bad", 32'h0, rd);
            chk_word("latch kept", latch, pin_out);
        end
        dir = 4'h7;
        wr(`GPIO_IDX_DIR, 32'h7);
        ext_drive <= 32'h5555_5555;
        ext_level <= 32'h0;
        repeat (6) @(posedge sys_clk);
        chk_word("short rack oe", 32'h00FF_FFFF, pin_oe);
        check_ports();
        wr(`GPIO_IDX_DIR, 32'h0);
        ext_drive <= 32'h0000_0001;
        wr(`GPIO_IDX_EVT_MASK, 32'h1);
        for (int m = 0; m < 4; m++) begin
            md = 2'(m);
            ext_level <= {31'h0, ~md[0]};
            repeat (6) @(posedge sys_clk);
            wr(`GPIO_IDX_IRQ_CTRL, {24'h0, 6'h3F, md});
            rdreg(`GPIO_IDX_IRQ_CTRL);
            wr(`GPIO_IDX_EVT_STATUS, 32'h1);
            rdreg(`GPIO_IDX_IRQ_CTRL);
            chk_word("ctrl idle", {24'h0, 6'h20, md}, rd);
            chk_flag("irq idle", 1'b0, irq);
            ext_level <= {31'h0, md[0]};
            repeat (8) @(posedge sys_clk);
            chk_flag("irq set", 1'b1, irq);
            rdreg(`GPIO_IDX_IRQ_CTRL);
            chk_word("ctrl hit", {24'h0, 6'h30, md}, rd);
            rdreg(`GPIO_IDX_IRQ_CTRL);
            exp_w = {24'h0, 1'b1, ~md[1], 4'h0, md};
            chk_word("ctrl again", exp_w, rd);
            wr(`GPIO_IDX_EVT_STATUS, 32'h1);
            repeat (2) @(posedge sys_clk);
            chk_flag("irq after", ~md[1], irq);
            if (md == 2'h1) begin
                wr(`GPIO_IDX_EVT_MASK, 32'h0);
                repeat (2) @(posedge sys_clk);
                chk_flag("irq masked", 1'b0, irq);
                wr(`GPIO_IDX_EVT_MASK, 32'h1);
                repeat (2) @(posedge sys_clk);
                chk_flag("irq unmasked", 1'b1, irq);
            end
        end
        wr(`GPIO_IDX_IRQ_CTRL, 32'h1);
        rdreg(`GPIO_IDX_IRQ_CTRL);
        wr(`GPIO_IDX_EVT_STATUS, 32'h1);
        repeat (4) @(posedge sys_clk);
        rdreg(`GPIO_IDX_IRQ_CTRL);
        chk_word("ctrl off", 32'h1, rd);
        chk_flag("irq off", 1'b0, irq);
        wr(`GPIO_IDX_DIR, 32'hF);
        rst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk_word("oe reset", 32'h0, pin_oe);
        rdreg(`GPIO_IDX_DIR);
        chk_word("dir reset", 32'h0, rd);
        rdreg(`GPIO_IDX_IRQ_CTRL);
        chk_word("ctrl reset", 32'h0, rd);
        stop_test();
    end
endmodule : quad_byte_digital_io_port_tb_top

`default_nettype wire
